// ### hw/clr_pkg.sv
// color pipeline package: widths, reset values, modes and carrier structs
// assumes a single display clock and a synchronous active-high reset
package clr_pkg;

    localparam int CLR_LVL_W     = 4;
    localparam int CLR_RG_IDX_W  = 3;
    localparam int CLR_B_IDX_W   = 2;
    localparam int CLR_RG_DEPTH  = 8;
    localparam int CLR_B_DEPTH   = 4;
    localparam int CLR_POS_W     = 7;
    localparam int CLR_FRM_W     = 6;
    localparam int CLR_BLINK_BIT = 5;

    localparam logic [3:0] CLR_LVL_RST = 4'h0;
    localparam logic [3:0] CLR_LVL_OFF = 4'h0;
    localparam logic [3:0] CLR_LVL_ON  = 4'hF;
    localparam logic [5:0] CLR_FRM_RST = 6'h00;

    typedef enum logic [1:0] {
        CLR_CUR_FIXED     = 2'h0,
        CLR_CUR_INVERT    = 2'h1,
        CLR_CUR_BLINK_FIX = 2'h2,
        CLR_CUR_BLINK_INV = 2'h3
    } clr_cur_mode_e;

    typedef enum logic [1:0] {
        CLR_PAL_RED   = 2'h0,
        CLR_PAL_GREEN = 2'h1,
        CLR_PAL_BLUE  = 2'h2
    } clr_pal_sel_e;

    typedef struct packed {
        logic                 en;
        clr_pal_sel_e         sel;
        logic [2:0]           idx;
        logic [3:0]           data;
    } clr_pal_wr_s;

    typedef struct packed {
        logic                 cursor_en;
        clr_cur_mode_e        cursor_mode_sel;
        logic                 cursor_red_on;
        logic                 cursor_green_on;
        logic                 cursor_blue_on;
        logic [6:0]           cursor_start_col;
        logic [6:0]           cursor_start_row;
        logic [6:0]           cursor_end_col;
        logic [6:0]           cursor_end_row;
    } clr_cur_cfg_s;

    typedef struct packed {
        logic                 valid;
        logic [7:0]           data;
        logic [6:0]           col;
        logic [6:0]           row;
    } clr_pix_s;

    typedef struct packed {
        logic                 valid;
        logic [3:0]           gray_r;
        logic [3:0]           gray_g;
        logic [3:0]           gray_b;
        logic                 lit_r;
        logic                 lit_g;
        logic                 lit_b;
    } clr_dot_s;

endpackage

// ### hw/clr_frc_dot.sv
// frame-skipping decision for one color component of one dot
// assumes level and phase are stable within the evaluating cycle
`timescale 1ns/1ps
`default_nettype none
module clr_frc_dot
    import clr_pkg::*;
#(
    parameter int LW = 4
) (
    input  wire logic [LW-1:0] level,
    input  wire logic [LW-1:0] phase,
    output logic               lit
);
    logic [LW:0]   on_cnt;
    logic [LW-1:0] rev;

    // 0 unlit, 1..14 give (v+1)/16, all ones fully lit
    always_comb begin
        if (level == '0) begin
            on_cnt = '0;
        end else begin
            on_cnt = {1'b0, level} + {{LW{1'b0}}, 1'b1};
        end
        for (int i = 0; i < LW; i++) begin
            rev[i] = phase[LW-1-i];
        end
        lit = ({1'b0, rev} < on_cnt);
    end
endmodule
`default_nettype wire

// ### hw/clr_pipe.sv
// palette lookup, four-color unpack, color window cursor and frame-skip gray
// assumes pixel stream with column/row counters and a frame-start pulse
`timescale 1ns/1ps
`default_nettype none
module clr_pipe
    import clr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         frame_start,
    input  wire logic         four_color_mode,
    input  wire clr_pal_wr_s  pal_wr,
    input  wire clr_cur_cfg_s cur_cfg,
    input  wire clr_pix_s     pix_in,
    output clr_dot_s          dot_out
);
    typedef struct packed {
        logic [5:0]            frame_cnt;
        logic [7:0][3:0]       red_palette_entry;
        logic [7:0][3:0]       green_palette_entry;
        logic [3:0][3:0]       blue_palette_entry;
        logic                  s1_valid;
        logic [3:0]            s1_r;
        logic [3:0]            s1_g;
        logic [3:0]            s1_b;
        logic                  s1_win;
        logic [3:0]            s1_ofs;
        clr_dot_s              out;
    } clr_state_s;

    clr_state_s st_q;
    clr_state_s st_d;
    logic [2:0] idx_r;
    logic [2:0] idx_g;
    logic [1:0] idx_b;
    logic [1:0] quad;
    logic       win;
    logic       blink_on;
    logic [3:0] phase_r;
    logic [3:0] phase_g;
    logic [3:0] phase_b;
    logic       lit_r;
    logic       lit_g;
    logic       lit_b;

    assign blink_on = st_q.frame_cnt[CLR_BLINK_BIT];
    assign phase_r  = st_q.frame_cnt[3:0] + st_q.s1_ofs;
    assign phase_g  = st_q.frame_cnt[3:0] + st_q.s1_ofs + 4'h5;
    assign phase_b  = st_q.frame_cnt[3:0] + st_q.s1_ofs + 4'hA;

    // one modulator per component, each dot phase-shifted by position
    clr_frc_dot #(.LW(CLR_LVL_W)) u_frc_r (.level(st_d.out.gray_r), .phase(phase_r), .lit(lit_r));
    clr_frc_dot #(.LW(CLR_LVL_W)) u_frc_g (.level(st_d.out.gray_g), .phase(phase_g), .lit(lit_g));
    clr_frc_dot #(.LW(CLR_LVL_W)) u_frc_b (.level(st_d.out.gray_b), .phase(phase_b), .lit(lit_b));

    always_comb begin
        st_d = st_q;

        // frame counter drives both gray phase and blink
        if (frame_start) begin
            st_d.frame_cnt = st_q.frame_cnt + 6'h01;
        end

        // palette programming
        if (pal_wr.en) begin
            unique case (pal_wr.sel)
                CLR_PAL_RED: begin
                    st_d.red_palette_entry[pal_wr.idx] = pal_wr.data;
                end
                CLR_PAL_GREEN: begin
                    st_d.green_palette_entry[pal_wr.idx] = pal_wr.data;
                end
                CLR_PAL_BLUE: begin
                    st_d.blue_palette_entry[pal_wr.idx[1:0]] = pal_wr.data;
                end
                default: begin
                    st_d.out = st_q.out;
                end
            endcase
        end

        // stage 1: index selection and palette lookup
        quad = pix_in.col[1:0];
        if (four_color_mode) begin
            idx_r = {1'b0, pix_in.data[7 - 2*quad -: 2]};
            idx_g = idx_r;
            idx_b = pix_in.data[7 - 2*quad -: 2];
        end else begin
            idx_r = pix_in.data[7:5];
            idx_g = pix_in.data[4:2];
            idx_b = pix_in.data[1:0];
        end
        win = (pix_in.col >= cur_cfg.cursor_start_col) && (pix_in.col <= cur_cfg.cursor_end_col) &&
              (pix_in.row >= cur_cfg.cursor_start_row) && (pix_in.row <= cur_cfg.cursor_end_row);
        st_d.s1_valid = pix_in.valid;
        st_d.s1_r     = st_q.red_palette_entry[idx_r];
        st_d.s1_g     = st_q.green_palette_entry[idx_g];
        st_d.s1_b     = st_q.blue_palette_entry[idx_b];
        st_d.s1_win   = win;
        st_d.s1_ofs   = {pix_in.col[0] ^ pix_in.row[0], pix_in.row[0],
                         pix_in.col[1] ^ pix_in.row[1], pix_in.row[1]};

        // stage 2: cursor overlay
        st_d.out.valid  = st_q.s1_valid;
        st_d.out.gray_r = st_q.s1_r;
        st_d.out.gray_g = st_q.s1_g;
        st_d.out.gray_b = st_q.s1_b;
        if (cur_cfg.cursor_en && st_q.s1_win) begin
            unique case (cur_cfg.cursor_mode_sel)
                CLR_CUR_FIXED: begin
                    st_d.out.gray_r = cur_cfg.cursor_red_on   ? CLR_LVL_ON : CLR_LVL_OFF;
                    st_d.out.gray_g = cur_cfg.cursor_green_on ? CLR_LVL_ON : CLR_LVL_OFF;
                    st_d.out.gray_b = cur_cfg.cursor_blue_on  ? CLR_LVL_ON : CLR_LVL_OFF;
                end
                CLR_CUR_INVERT: begin
                    st_d.out.gray_r = ~st_q.s1_r;
                    st_d.out.gray_g = ~st_q.s1_g;
                    st_d.out.gray_b = ~st_q.s1_b;
                end
                CLR_CUR_BLINK_FIX: begin
                    if (blink_on) begin
                        st_d.out.gray_r = cur_cfg.cursor_red_on   ? CLR_LVL_ON : CLR_LVL_OFF;
                        st_d.out.gray_g = cur_cfg.cursor_green_on ? CLR_LVL_ON : CLR_LVL_OFF;
                        st_d.out.gray_b = cur_cfg.cursor_blue_on  ? CLR_LVL_ON : CLR_LVL_OFF;
                    end
                end
                CLR_CUR_BLINK_INV: begin
                    if (blink_on) begin
                        st_d.out.gray_r = ~st_q.s1_r;
                        st_d.out.gray_g = ~st_q.s1_g;
                        st_d.out.gray_b = ~st_q.s1_b;
                    end
                end
            endcase
        end
        st_d.out.lit_r = lit_r;
        st_d.out.lit_g = lit_g;
        st_d.out.lit_b = lit_b;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dot_out = st_q.out;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [3:0] chk_r;
    logic [3:0] chk_g;
    logic [3:0] chk_b;
    assign chk_r = st_q.s1_r;
    assign chk_g = st_q.s1_g;
    assign chk_b = st_q.s1_b;

    property p_no_cursor;
        (!cur_cfg.cursor_en || !st_q.s1_win) ##0 $stable(cur_cfg) |=>
            dot_out.gray_r == $past(chk_r) && dot_out.gray_b == $past(chk_b);
    endproperty
    a_no_cursor: assert property (p_no_cursor) else $error("cursor applied while off or outside window");

    property p_fixed;
        cur_cfg.cursor_en && st_q.s1_win && cur_cfg.cursor_mode_sel == CLR_CUR_FIXED |=>
            dot_out.gray_r == {4{$past(cur_cfg.cursor_red_on)}} &&
            dot_out.gray_g == {4{$past(cur_cfg.cursor_green_on)}};
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed cursor color wrong");

    property p_invert;
        cur_cfg.cursor_en && st_q.s1_win && cur_cfg.cursor_mode_sel == CLR_CUR_INVERT |=>
            dot_out.gray_g == ~$past(chk_g) && dot_out.gray_b == ~$past(chk_b);
    endproperty
    a_invert: assert property (p_invert) else $error("inverted cursor wrong");

    property p_blink_fix;
        cur_cfg.cursor_en && st_q.s1_win && cur_cfg.cursor_mode_sel == CLR_CUR_BLINK_FIX && !blink_on |=>
            dot_out.gray_r == $past(chk_r);
    endproperty
    a_blink_fix: assert property (p_blink_fix) else $error("blink off phase not normal");

    property p_blink_inv;
        cur_cfg.cursor_en && st_q.s1_win && cur_cfg.cursor_mode_sel == CLR_CUR_BLINK_INV && blink_on |=>
            dot_out.gray_r == ~$past(chk_r);
    endproperty
    a_blink_inv: assert property (p_blink_inv) else $error("blink on phase not inverted");

    property p_blink_period;
        frame_start && st_q.frame_cnt[4:0] == 5'h1F |=> blink_on != $past(blink_on);
    endproperty
    a_blink_period: assert property (p_blink_period) else $error("blink phase not toggled after 32 frames");

    property p_lvl_edges;
        (st_d.out.gray_r == CLR_LVL_OFF |=> !dot_out.lit_r) and
        (st_d.out.gray_r == CLR_LVL_ON  |=> dot_out.lit_r);
    endproperty
    a_lvl_edges: assert property (p_lvl_edges) else $error("unlit or all-lit level modulated");

    property p_four_color;
        pix_in.valid && four_color_mode && pal_wr.en == 1'b0 |=>
            st_q.s1_r == st_q.red_palette_entry[{1'b0, $past(pix_in.data[7 - 2*pix_in.col[1:0] -: 2])}];
    endproperty
    a_four_color: assert property (p_four_color) else $error("four-color index wrong");

    property p_pipe_valid;
        pix_in.valid |=> st_q.s1_valid ##1 dot_out.valid;
    endproperty
    a_pipe_valid: assert property (p_pipe_valid) else $error("pixel lost in pipeline");
endmodule
`default_nettype wire

// ### tb/clr_seg_model.sv
// segment stage model: counts lit dots of each component between clears
// assumes the registered dot stream of clr_pipe on the same clock
`timescale 1ns/1ps
`default_nettype none
module clr_seg_model
    import clr_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     clr,
    input  wire clr_dot_s dot,
    output logic [4:0]    cnt_r,
    output logic [4:0]    cnt_g,
    output logic [4:0]    cnt_b
);
    // only valid dots drive the panel, so only they are counted
    always_ff @(posedge clk) begin
        if (clr) begin
            cnt_r <= 5'h00;
            cnt_g <= 5'h00;
            cnt_b <= 5'h00;
        end else if (dot.valid) begin
            cnt_r <= cnt_r + 5'(dot.lit_r);
            cnt_g <= cnt_g + 5'(dot.lit_g);
            cnt_b <= cnt_b + 5'(dot.lit_b);
        end
    end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// testbench: blink, palette, four-color, cursor and frame-skip tests of clr_pipe
// assumes clr_seg_model counts lit dots at the output
`timescale 1ns/1ps
`default_nettype none
module testbench
    import clr_pkg::*;
;
    logic         clk;
    logic         rst;
    logic         frame_start;
    logic         four_color_mode;
    logic         seg_clr;
    clr_pal_wr_s  pal_wr;
    clr_cur_cfg_s cur_cfg;
    clr_pix_s     pix_in;
    clr_dot_s     dot_out;
    logic [4:0]   cnt_r;
    logic [4:0]   cnt_g;
    logic [4:0]   cnt_b;
    int           fail_count;
    int           compares;
    logic [3:0]   rp [8] = '{4'h0, 4'h1, 4'h5, 4'h7, 4'h9, 4'hC, 4'hE, 4'hF};
    logic [3:0]   gp [8] = '{4'hF, 4'hE, 4'hA, 4'h8, 4'h6, 4'h3, 4'h1, 4'h0};
    logic [3:0]   bp [4] = '{4'h2, 4'h4, 4'hB, 4'hD};

    clr_pipe i_dut (.clk(clk), .rst(rst), .frame_start(frame_start), .four_color_mode(four_color_mode),
                    .pal_wr(pal_wr), .cur_cfg(cur_cfg), .pix_in(pix_in), .dot_out(dot_out));
    clr_seg_model i_seg (.clk(clk), .clr(seg_clr), .dot(dot_out), .cnt_r(cnt_r), .cnt_g(cnt_g), .cnt_b(cnt_b));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input clr_pal_sel_e s, input logic [2:0] i, input logic [3:0] d);
        @(posedge clk);
        pal_wr <= '{en: 1'b1, sel: s, idx: i, data: d};
        @(posedge clk);
        pal_wr.en <= 1'b0;
    endtask

    // one pixel in, its dot checked one edge after the design takes it
    task automatic px(input logic [7:0] d, input logic [6:0] c, input logic [6:0] r,
                      input logic [11:0] e, input logic cb);
        @(posedge clk);
        pix_in <= '{valid: 1'b1, data: d, col: c, row: r};
        @(posedge clk);
        pix_in.valid <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(dot_out.valid), 16'h0001);
        chk(16'(dot_out.gray_r), 16'(e[11:8]));
        chk(16'(dot_out.gray_g), 16'(e[7:4]));
        if (cb) chk(16'(dot_out.gray_b), 16'(e[3:0]));
    endtask

    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk);
            frame_start <= 1'b1;
        end
        @(posedge clk);
        frame_start <= 1'b0;
    endtask

    // window columns 2..4, rows 3..5, cursor color red and blue
    task automatic cur(input logic en, input logic [1:0] m);
        @(posedge clk);
        cur_cfg <= '{cursor_en: en, cursor_mode_sel: clr_cur_mode_e'(m), cursor_red_on: 1'b1,
                     cursor_green_on: 1'b0, cursor_blue_on: 1'b1, cursor_start_col: 7'h02,
                     cursor_start_row: 7'h03, cursor_end_col: 7'h04, cursor_end_row: 7'h05};
    endtask

    function automatic logic [15:0] lit_cnt(input logic [3:0] v);
        return (v == 4'h0) ? 16'h0000 : 16'(v) + 16'h0001;
    endfunction

    initial begin
        rst = 1'b1;
        frame_start = 1'b0;
        four_color_mode = 1'b0;
        seg_clr = 1'b0;
        pal_wr = '0;
        cur_cfg = '0;
        pix_in = '0;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // palettes are zero after reset, blink starts in the normal phase
        cur(1'b1, 2'h2);
        px(8'h00, 7'h03, 7'h04, 12'h000, 1'b1);
        frames(32);
        px(8'h00, 7'h03, 7'h04, 12'hF0F, 1'b1);
        cur(1'b1, 2'h3);
        px(8'h00, 7'h03, 7'h04, 12'hFFF, 1'b1);
        frames(32);
        px(8'h00, 7'h03, 7'h04, 12'h000, 1'b1);
        $display("test blink done");
        cur(1'b0, 2'h0);
        for (int i = 0; i < 8; i++) begin
            wr(CLR_PAL_RED, i[2:0], rp[i]);
            wr(CLR_PAL_GREEN, i[2:0], gp[i]);
            if (i < 4) wr(CLR_PAL_BLUE, i[2:0], bp[i]);
        end
        for (int i = 0; i < 8; i++) begin
            px({i[2:0], ~i[2:0], i[1:0]}, 7'h00, 7'h00, {rp[i], gp[7-i], bp[i[1:0]]}, 1'b1);
        end
        $display("test palette done");
        @(posedge clk);
        four_color_mode <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            px(8'h1B, c[6:0], 7'h00, {rp[c[1:0]], gp[c[1:0]], 4'h0}, 1'b0);
        end
        @(posedge clk);
        four_color_mode <= 1'b0;
        $display("test four color done");
        cur(1'b1, 2'h0);
        px(8'h4A, 7'h02, 7'h03, 12'hF0F, 1'b1);
        px(8'h4A, 7'h04, 7'h05, 12'hF0F, 1'b1);
        px(8'h4A, 7'h01, 7'h03, 12'h5AB, 1'b1);
        px(8'h4A, 7'h05, 7'h05, 12'h5AB, 1'b1);
        px(8'h4A, 7'h02, 7'h06, 12'h5AB, 1'b1);
        cur(1'b1, 2'h1);
        px(8'h4A, 7'h03, 7'h04, 12'hA54, 1'b1);
        for (int m = 0; m < 4; m++) begin
            cur(1'b0, m[1:0]);
            px(8'h4A, 7'h03, 7'h04, 12'h5AB, 1'b1);
        end
        $display("test cursor done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            seg_clr <= 1'b1;
            @(posedge clk);
            seg_clr <= 1'b0;
            repeat (16) begin
                @(posedge clk);
                pix_in <= '{valid: 1'b1, data: {i[2:0], ~i[2:0], i[1:0]}, col: 7'h00, row: 7'h00};
                frame_start <= 1'b1;
            end
            @(posedge clk);
            pix_in.valid <= 1'b0;
            frame_start <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk(16'(cnt_r), lit_cnt(rp[i]));
            chk(16'(cnt_g), lit_cnt(gp[7-i]));
            chk(16'(cnt_b), lit_cnt(bp[i[1:0]]));
        end
        $display("test frame skip done");
        report_and_stop();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
